// ### design/shs_params.svh
// Constants for the scrubber health supervisor: offsets, fields, resets, timing.
// Assumes a 125 MHz system clock and a 32-bit APB register port.
`ifndef SHS_PARAMS_SVH
`define SHS_PARAMS_SVH

// Clock and timing figures.
`define SHS_CLK_PERIOD_NS 8
`define SHS_ONE_SEC_NS 1000000000
`define SHS_HB_GAP_NS 1000
`define SHS_HB_GAP_CYCLES (`SHS_HB_GAP_NS / `SHS_CLK_PERIOD_NS)
`define SHS_NUM_SLICES 2

// Register byte offsets.
`define SHS_ADDR_CTRL 12'h000
`define SHS_ADDR_CMD_PERIOD 12'h004
`define SHS_ADDR_STATUS 12'h008
`define SHS_ADDR_EVENT 12'h00C
`define SHS_ADDR_MASK 12'h010
`define SHS_ADDR_REPEAT 12'h014

// Control fields.
`define SHS_CTRL_ENABLE 0
`define SHS_CTRL_CMD_EN 1
`define SHS_CTRL_REPEAT_EN 2
`define SHS_CTRL_FAULT_CLR 3

// Event fields.
`define SHS_EV_HEARTBEAT 0
`define SHS_EV_CRC_TIMEOUT 1
`define SHS_EV_REPORT_TIMEOUT 2
`define SHS_EV_DWELL 3
`define SHS_EV_HALT 4
`define SHS_EV_REPEAT 5
`define SHS_EV_IDLE_ENTRY 6
`define SHS_EV_WIDTH 7
`define SHS_EV_ESSENTIAL 7'h1F

// Status register field positions.
`define SHS_ST_OBSERVE 0
`define SHS_ST_HALTED 8
`define SHS_ST_CMD 16
`define SHS_ST_FAULT 24

// Reset values.
`define SHS_RST_CTRL 3'h7
`define SHS_RST_CMD_PERIOD 16'h003C
`define SHS_RST_MASK 7'h7F
`define SHS_RST_REPEAT 8'h04

`endif

// ### design/shs_pkg.sv
// Types for the scrubber health supervisor.
// Assumes shs_params.svh supplies all numeric constants.
package shs_pkg;

	// Periodic status command sequencer.
	typedef enum logic [1:0]
	{
		SHS_CMD_IDLE = 2'b00,
		SHS_CMD_PENDING = 2'b01,
		SHS_CMD_WAIT = 2'b10
	} shs_cmd_state_t;

endpackage

// ### design/shs_supervisor.sv
// Scrubber health supervisor: watchdog over a configuration scrubbing controller.
// Assumes decoded monitor-link events arrive as one-cycle pulses on the system clock.
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "shs_params.svh"

// Function
// - CRC-failure indicator is meaningful only while observing.
// - Per-slice CRC indicators are ORed onto one pin; correcting flags stay per slice.
// - Status commands are only sent in observation; otherwise held until then.
// - Controller normally returns to observation or idle after correction.
// - Idle entry only after uncorrectable error or command; else flagged.
// - Halt means an inconsistent internal state was found.
// - Halt is all five indicators high or a halted message.
module shs_supervisor
	import shs_pkg::*;
#(
	parameter int unsigned ONE_SEC_CYCLES = `SHS_ONE_SEC_NS / `SHS_CLK_PERIOD_NS
)
(
	// Clock, reset, enable.
	input wire logic clock_in,
	input wire logic rstn_in,
	input wire logic clk_en_in,
	// APB slave.
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Controller status, one bit per die slice.
	input wire logic [`SHS_NUM_SLICES-1:0] status_initialization_in,
	input wire logic [`SHS_NUM_SLICES-1:0] status_observation_in,
	input wire logic [`SHS_NUM_SLICES-1:0] status_correction_in,
	input wire logic [`SHS_NUM_SLICES-1:0] status_classification_in,
	input wire logic [`SHS_NUM_SLICES-1:0] status_injection_in,
	input wire logic [`SHS_NUM_SLICES-1:0] status_heartbeat_in,
	input wire logic [`SHS_NUM_SLICES-1:0] status_uncorrectable_in,
	input wire logic [`SHS_NUM_SLICES-1:0] crc_fail_slice_in,
	// Decoded monitor-link events.
	input wire logic halted_message_in,
	input wire logic state_change_in,
	input wire logic status_report_in,
	input wire logic idle_command_in,
	input wire logic corrected_valid_in,
	input wire logic [31:0] corrected_addr_in,
	input wire logic status_cmd_ready_in,
	output logic status_cmd_out,
	// System outputs.
	output logic crc_fail_out,
	output logic fault_out,
	output logic irq_out
);

	localparam int N = `SHS_NUM_SLICES;

	logic [2:0] ctrl;
	logic [15:0] cmd_period;
	logic [7:0] repeat_limit;
	logic [`SHS_EV_WIDTH-1:0] event_mask;
	logic [`SHS_EV_WIDTH-1:0] event_status;
	logic [`SHS_EV_WIDTH-1:0] ev_set;
	logic [`SHS_EV_WIDTH-1:0] ev_clr;
	logic [N-1:0] halted;
	logic [N-1:0] observing;
	logic [N-1:0] busy;
	logic [N-1:0] idle_now;
	logic [N-1:0] hb_fault;
	logic [N-1:0] dwell_fault;
	logic [N-1:0] idle_fault;
	logic any_halt;
	logic apb_setup;
	logic apb_done;
	logic addr_ok;
	logic [31:0] read_data;
	logic fault_clr;
	logic crc_any;
	logic crc_entered;
	logic crc_watch;
	logic [31:0] crc_count;
	logic crc_fault;
	logic [31:0] sec_count;
	logic sec_tick;
	logic [15:0] period_count;
	logic [31:0] resp_count;
	logic report_fault;
	shs_cmd_state_t cmd_state;
	shs_cmd_state_t next_cmd_state;
	logic idle_cmd_seen;
	logic [31:0] last_addr;
	logic [7:0] repeat_count;
	logic repeat_fault;

	// Controller state decode per slice; all five indicators high marks halt.
	assign halted = status_initialization_in & status_observation_in & status_correction_in
		& status_classification_in & status_injection_in;
	assign observing = status_observation_in & ~halted;
	assign busy = (status_correction_in | status_classification_in) & ~halted;
	assign idle_now = ~(status_initialization_in | status_observation_in | status_correction_in
		| status_classification_in | status_injection_in);
	assign any_halt = (|halted) | halted_message_in;

	// Per-slice heartbeat, dwell and idle-entry watchdogs.
	genvar gi;
	generate
		for (gi = 0; gi < N; gi = gi + 1)
		begin : g_slice
			logic [15:0] hb_count;
			logic [31:0] dwell_count;
			logic prev_idle;

			// Gap since the last heartbeat; only counted while observing.
			always_ff @(posedge clock_in or negedge rstn_in)
			begin
				if (!rstn_in)
					hb_count <= 16'h0000;
				else if (clk_en_in)
				begin
					if (!observing[gi] || status_heartbeat_in[gi])
						hb_count <= 16'h0000;
					else if (hb_count != 16'(`SHS_HB_GAP_CYCLES))
						hb_count <= hb_count + 16'h0001;
				end
			end
			assign hb_fault[gi] = observing[gi] & ~status_heartbeat_in[gi]
				& (hb_count == 16'(`SHS_HB_GAP_CYCLES - 1));

			// Continuous time in correction or classification, restarted on exit.
			always_ff @(posedge clock_in or negedge rstn_in)
			begin
				if (!rstn_in)
					dwell_count <= 32'h0000_0000;
				else if (clk_en_in)
				begin
					if (!busy[gi])
						dwell_count <= 32'h0000_0000;
					else if (dwell_count != 32'(ONE_SEC_CYCLES))
						dwell_count <= dwell_count + 32'h0000_0001;
				end
			end
			assign dwell_fault[gi] = busy[gi] & (dwell_count == 32'(ONE_SEC_CYCLES - 1));

			// Reset value of one keeps the boot idle from looking like an entry.
			always_ff @(posedge clock_in or negedge rstn_in)
			begin
				if (!rstn_in)
					prev_idle <= 1'b1;
				else if (clk_en_in)
					prev_idle <= idle_now[gi];
			end
			assign idle_fault[gi] = idle_now[gi] & ~prev_idle & ~status_uncorrectable_in[gi]
				& ~idle_cmd_seen & ~idle_command_in;
		end
	endgenerate

	// Remembers an idle command until the controller goes idle.
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
			idle_cmd_seen <= 1'b0;
		else if (clk_en_in)
		begin
			if (idle_command_in)
				idle_cmd_seen <= 1'b1;
			else if (|idle_now)
				idle_cmd_seen <= 1'b0;
		end
	end

	// The CRC indicator counts only while observing and until a state change is reported or correction begins.
	assign crc_any = |crc_fail_slice_in;
	assign crc_watch = crc_any & (|observing) & ~crc_entered & ~(|status_correction_in);

	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
			crc_entered <= 1'b0;
		else if (clk_en_in)
		begin
			if (!crc_any)
				crc_entered <= 1'b0;
			else if (state_change_in || (|status_correction_in))
				crc_entered <= 1'b1;
		end
	end

	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
			crc_count <= 32'h0000_0000;
		else if (clk_en_in)
		begin
			if (!crc_watch)
				crc_count <= 32'h0000_0000;
			else if (crc_count != 32'(ONE_SEC_CYCLES))
				crc_count <= crc_count + 32'h0000_0001;
		end
	end
	assign crc_fault = crc_watch & (crc_count == 32'(ONE_SEC_CYCLES - 1));

	// Registered wired-OR of the slice CRC indicators for the device pin.
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
			crc_fail_out <= 1'b0;
		else if (clk_en_in)
			crc_fail_out <= crc_any;
	end

	// Seconds prescaler for the slow status command period.
	assign sec_tick = (sec_count == 32'(ONE_SEC_CYCLES - 1));

	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
			sec_count <= 32'h0000_0000;
		else if (clk_en_in)
			sec_count <= sec_tick ? 32'h0000_0000 : sec_count + 32'h0000_0001;
	end

	// Seconds since the last command; a period of zero disables the check.
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
			period_count <= 16'h0000;
		else if (clk_en_in)
		begin
			if (cmd_state != SHS_CMD_IDLE)
				period_count <= 16'h0000;
			else if (sec_tick)
				period_count <= period_count + 16'h0001;
		end
	end

	// Status command sequencer; the command waits while not observing.
	always_comb
	begin
		next_cmd_state = cmd_state;
		case (cmd_state)
			SHS_CMD_IDLE:
				if (ctrl[`SHS_CTRL_CMD_EN] && ctrl[`SHS_CTRL_ENABLE] && cmd_period != 16'h0000
					&& period_count >= cmd_period)
					next_cmd_state = SHS_CMD_PENDING;
			SHS_CMD_PENDING:
				if ((&observing) && status_cmd_ready_in)
					next_cmd_state = SHS_CMD_WAIT;
			SHS_CMD_WAIT:
				if (status_report_in || state_change_in || report_fault)
					next_cmd_state = SHS_CMD_IDLE;
			default:
				next_cmd_state = SHS_CMD_IDLE;
		endcase
	end

	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
			cmd_state <= SHS_CMD_IDLE;
		else if (clk_en_in)
			cmd_state <= next_cmd_state;
	end

	// One-cycle command strobe on the move from pending to waiting.
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
			status_cmd_out <= 1'b0;
		else if (clk_en_in)
			status_cmd_out <= (cmd_state == SHS_CMD_PENDING) && (next_cmd_state == SHS_CMD_WAIT);
	end

	// Reply timer runs only while a report is awaited.
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
			resp_count <= 32'h0000_0000;
		else if (clk_en_in)
		begin
			if (cmd_state != SHS_CMD_WAIT)
				resp_count <= 32'h0000_0000;
			else if (resp_count != 32'(ONE_SEC_CYCLES))
				resp_count <= resp_count + 32'h0000_0001;
		end
	end
	assign report_fault = (cmd_state == SHS_CMD_WAIT) && !status_report_in && !state_change_in
		&& (resp_count == 32'(ONE_SEC_CYCLES - 1));

	// Same-address correction tracker; informational, not an essential fault.
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			last_addr <= 32'h0000_0000;
			repeat_count <= 8'h00;
		end
		else if (clk_en_in && corrected_valid_in)
		begin
			last_addr <= corrected_addr_in;
			if (corrected_addr_in != last_addr)
				repeat_count <= 8'h00;
			else if (repeat_count != 8'hFF)
				repeat_count <= repeat_count + 8'h01;
		end
	end
	assign repeat_fault = ctrl[`SHS_CTRL_REPEAT_EN] && corrected_valid_in
		&& (corrected_addr_in == last_addr)
		&& (8'(repeat_count + 8'h01) == repeat_limit);

	// Event gathering; every event source is gated by the enable bit.
	always_comb
	begin
		ev_set = '0;
		if (ctrl[`SHS_CTRL_ENABLE])
		begin
			ev_set[`SHS_EV_HEARTBEAT] = |hb_fault;
			ev_set[`SHS_EV_CRC_TIMEOUT] = crc_fault;
			ev_set[`SHS_EV_REPORT_TIMEOUT] = report_fault;
			ev_set[`SHS_EV_DWELL] = |dwell_fault;
			ev_set[`SHS_EV_HALT] = any_halt;
			ev_set[`SHS_EV_REPEAT] = repeat_fault;
			ev_set[`SHS_EV_IDLE_ENTRY] = |idle_fault;
		end
	end

	// APB decode: zero-wait answer, pready rises in the access phase.
	assign apb_setup = psel_in && !penable_in;
	assign apb_done = psel_in && penable_in && pready_out;
	assign ev_clr = (apb_done && !pwrite_in && paddr_in == `SHS_ADDR_EVENT) ? '1 : '0;
	assign fault_clr = apb_done && pwrite_in && paddr_in == `SHS_ADDR_CTRL
		&& pwdata_in[`SHS_CTRL_FAULT_CLR];

	always_comb
	begin
		read_data = 32'h0000_0000;
		addr_ok = 1'b1;
		if (paddr_in == `SHS_ADDR_CTRL)
			read_data[2:0] = ctrl;
		else if (paddr_in == `SHS_ADDR_CMD_PERIOD)
			read_data[15:0] = cmd_period;
		else if (paddr_in == `SHS_ADDR_STATUS)
		begin
			read_data[`SHS_ST_OBSERVE +: N] = observing;
			read_data[`SHS_ST_HALTED +: N] = halted;
			read_data[`SHS_ST_CMD +: 2] = cmd_state;
			read_data[`SHS_ST_FAULT] = fault_out;
		end
		else if (paddr_in == `SHS_ADDR_EVENT)
			read_data[`SHS_EV_WIDTH-1:0] = event_status;
		else if (paddr_in == `SHS_ADDR_MASK)
			read_data[`SHS_EV_WIDTH-1:0] = event_mask;
		else if (paddr_in == `SHS_ADDR_REPEAT)
			read_data[7:0] = repeat_limit;
		else
			addr_ok = 1'b0;
	end

	// Bus answer registers; unmapped addresses answer with pslverr.
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
		end
		else if (clk_en_in)
		begin
			pready_out <= apb_setup;
			pslverr_out <= apb_setup && !addr_ok;
			prdata_out <= apb_setup && !pwrite_in ? read_data : 32'h0000_0000;
		end
	end

	// Software-written configuration, committed at the completing edge.
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			ctrl <= `SHS_RST_CTRL;
			cmd_period <= `SHS_RST_CMD_PERIOD;
			event_mask <= `SHS_RST_MASK;
			repeat_limit <= `SHS_RST_REPEAT;
		end
		else if (clk_en_in && apb_done && pwrite_in)
		begin
			if (paddr_in == `SHS_ADDR_CTRL)
				ctrl <= pwdata_in[2:0];
			else if (paddr_in == `SHS_ADDR_CMD_PERIOD)
				cmd_period <= pwdata_in[15:0];
			else if (paddr_in == `SHS_ADDR_MASK)
				event_mask <= pwdata_in[`SHS_EV_WIDTH-1:0];
			else if (paddr_in == `SHS_ADDR_REPEAT)
				repeat_limit <= pwdata_in[7:0];
		end
	end

	// Sticky events, read-to-clear; a new event in the clearing cycle survives.
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
			event_status <= '0;
		else if (clk_en_in)
			event_status <= (event_status & ~ev_clr) | ev_set;
	end

	// Essential fault latch and interrupt level, both straight from flops.
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			fault_out <= 1'b0;
			irq_out <= 1'b0;
		end
		else if (clk_en_in)
		begin
			fault_out <= (fault_out && !fault_clr) || |(ev_set & `SHS_EV_ESSENTIAL);
			irq_out <= |(((event_status & ~ev_clr) | ev_set) & event_mask);
		end
	end

endmodule
`default_nettype wire

// ### verif/shs_ctrl_model.sv
// Behavioural scrubbing controller with two die slices, faults chosen by mode.
// Assumes the bench changes mode only between scenarios.
`timescale 1ns/100ps
`default_nettype none

module shs_ctrl_model
(
	// Clock, reset, scenario.
	input wire logic clock_in,
	input wire logic rstn_in,
	input wire logic [2:0] mode_in,
	input wire logic slice_in,
	input wire logic status_cmd_in,
	// Status and monitor events.
	output logic [1:0] obs_out,
	output logic [1:0] corr_out,
	output logic [1:0] halt_out,
	output logic [1:0] hb_out,
	output logic [1:0] crc_out,
	output logic halted_msg_out,
	output logic state_chg_out,
	output logic report_out,
	output logic fix_valid_out,
	output logic [31:0] fix_addr_out,
	output logic ready_out
);
	logic [2:0] last_mode;
	logic [7:0] age;
	logic [5:0] beat;
	logic [3:0] reply;
	logic [1:0] sel;
	logic [1:0] busy;

	// Mode 3 corrects briefly, mode 4 sticks in correction, mode 5 halts.
	assign sel = slice_in ? 2'h2 : 2'h1;
	assign busy = (mode_in == 3'h4 || (mode_in == 3'h3 && age < 8'h14)) ? sel : 2'h0;
	assign halt_out = (mode_in == 3'h5) ? sel : 2'h0;
	assign obs_out = ~busy;
	assign corr_out = busy | halt_out;
	assign hb_out = (beat == 6'h00 && mode_in != 3'h1) ? obs_out & ~halt_out : 2'h0;
	assign crc_out = (mode_in == 3'h2 || (mode_in == 3'h3 && age < 8'h14)) ? sel : 2'h0;
	assign halted_msg_out = mode_in == 3'h7 && age == 8'h02;
	// Mode 2 keeps observing while the CRC flag stands, so it reports no state change.
	assign state_chg_out = age == 8'h01 && mode_in != 3'h2;
	assign report_out = reply == 4'h1 && mode_in != 3'h6;
	// Five corrections of one address in mode 3 trip a repeat limit of four.
	assign fix_valid_out = mode_in == 3'h3 && last_mode == 3'h3
		&& age > 8'h0E && age < 8'h14;
	assign fix_addr_out = 32'h0000_0040;
	assign ready_out = ~beat[1];

	// Replies wait while any slice is busy, as a held command would.
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			last_mode <= 3'h0;
			age <= 8'h00;
			beat <= 6'h00;
			reply <= 4'h0;
		end
		else
		begin
			beat <= beat + 6'h01;
			last_mode <= mode_in;
			age <= (mode_in != last_mode) ? 8'h00 : age + {7'h00, age != 8'hFF};
			if (status_cmd_in)
				reply <= 4'hA;
			else if (reply != 4'h0 && &obs_out)
				reply <= reply - 4'h1;
		end
	end
endmodule
`default_nettype wire

// ### verif/shs_supervisor_props.sv
// Port checker for the scrubber health supervisor.
// Assumes the enable input is held high and the checker is bound below.
`timescale 1ns/100ps
`default_nettype none
`include "shs_params.svh"

module shs_supervisor_props
#(
	parameter int unsigned ONE_SEC_CYCLES = 200
)
(
	// Clock and reset.
	input wire logic clock_in,
	input wire logic rstn_in,
	// APB side.
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic pready_out,
	// Controller side.
	input wire logic [`SHS_NUM_SLICES-1:0] status_initialization_in,
	input wire logic [`SHS_NUM_SLICES-1:0] status_observation_in,
	input wire logic [`SHS_NUM_SLICES-1:0] status_correction_in,
	input wire logic [`SHS_NUM_SLICES-1:0] status_classification_in,
	input wire logic [`SHS_NUM_SLICES-1:0] status_injection_in,
	input wire logic [`SHS_NUM_SLICES-1:0] crc_fail_slice_in,
	input wire logic halted_message_in,
	input wire logic status_cmd_ready_in,
	// Supervisor outputs.
	input wire logic status_cmd_out,
	input wire logic crc_fail_out,
	input wire logic fault_out
);
	logic halt_any;
	logic fault_clr;
	logic all_obs;
	logic [31:0] dwell_cnt [`SHS_NUM_SLICES];

	// A slice with all indicators high has halted; only a completed write clears the fault.
	assign halt_any = |(status_initialization_in & status_observation_in & status_correction_in
		& status_classification_in & status_injection_in);
	assign fault_clr = psel_in && penable_in && pready_out && pwrite_in
		&& paddr_in == `SHS_ADDR_CTRL && pwdata_in[`SHS_CTRL_FAULT_CLR];
	assign all_obs = &status_observation_in;

	// Busy time per slice; halt is not a dwell, so it restarts the count.
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		for (int i = 0; i < `SHS_NUM_SLICES; i++)
		begin
			if (!rstn_in)
				dwell_cnt[i] <= 32'h0000_0000;
			else if (!(status_correction_in[i] || status_classification_in[i]) || halt_any)
				dwell_cnt[i] <= 32'h0000_0000;
			else if (dwell_cnt[i] < ONE_SEC_CYCLES + 8)
				dwell_cnt[i] <= dwell_cnt[i] + 32'h0000_0001;
		end
	end

	default clocking @(posedge clock_in); endclocking
	default disable iff (!rstn_in);

	apb_answer_a: assert property (psel_in && !penable_in |=> pready_out)
		else $error("no answer one cycle after setup");
	crc_merge_a: assert property (crc_fail_out == |$past(crc_fail_slice_in))
		else $error("merged crc flag wrong");
	halt_state_a: assert property (halt_any |-> ##[1:2] fault_out)
		else $error("halt indicators not flagged");
	halt_msg_a: assert property (halted_message_in |-> ##[1:2] fault_out)
		else $error("halted message not flagged");
	fault_hold_a: assert property (fault_out && !fault_clr |=> fault_out)
		else $error("fault dropped without clear");
	cmd_observe_a: assert property (status_cmd_out
		|-> $past(all_obs) && $past(status_cmd_ready_in))
		else $error("command sent outside observation");
	cmd_pulse_a: assert property (status_cmd_out |=> !status_cmd_out)
		else $error("command pulse too long");
	dwell_limit_a: assert property ((dwell_cnt[0] == ONE_SEC_CYCLES + 4
		|| dwell_cnt[1] == ONE_SEC_CYCLES + 4) |-> fault_out)
		else $error("long dwell not flagged");
endmodule

bind shs_supervisor shs_supervisor_props #(.ONE_SEC_CYCLES(ONE_SEC_CYCLES)) u_props (
	.clock_in(clock_in), .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in),
	.pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out),
	.status_initialization_in(status_initialization_in),
	.status_observation_in(status_observation_in), .status_correction_in(status_correction_in),
	.status_classification_in(status_classification_in),
	.status_injection_in(status_injection_in), .crc_fail_slice_in(crc_fail_slice_in),
	.halted_message_in(halted_message_in), .status_cmd_ready_in(status_cmd_ready_in),
	.status_cmd_out(status_cmd_out), .crc_fail_out(crc_fail_out), .fault_out(fault_out));
`default_nettype wire

// ### verif/shs_supervisor_tb_top.sv
// Self-checking bench for the scrubber health supervisor.
// Assumes a one-second count shortened to 200 cycles.
`timescale 1ns/100ps
`default_nettype none
`include "shs_params.svh"

module shs_supervisor_tb_top;
	localparam int ONE_SEC = 200;
	typedef struct {logic rd; logic [31:0] d; logic e;} shs_exp_t;
	logic clock_in, rstn_in, psel_in, penable_in, pwrite_in, slice;
	logic [11:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out, fixa, mask;
	logic pready_out, pslverr_out, cmd_out, crc_fail_out, fault_out, irq_out;
	logic [1:0] obs, corr, halt, hb, crc;
	logic hmsg, schg, rep, fixv, rdy;
	logic [2:0] mode;
	int err_count, checked, cmd_cnt;
	shs_exp_t exp_q[$];
	logic [11:0] ra [7] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018};
	logic [31:0] rv [7] = '{`SHS_RST_CTRL, `SHS_RST_CMD_PERIOD, 32'h3, 32'h0, `SHS_RST_MASK,
		`SHS_RST_REPEAT, 32'h0};
	logic [2:0] rm [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7, 3'h6};
	int rw [8] = '{300, 200, 260, 260, 260, 20, 20, 500};
	logic [31:0] re [8] = '{32'h0, 32'h1, 32'h2, 32'h20, 32'h8, 32'h10, 32'h10, 32'h4};
	logic [7:0] rf = 8'hF6;

	shs_supervisor #(.ONE_SEC_CYCLES(ONE_SEC)) u_dut (.clock_in(clock_in), .rstn_in(rstn_in),
		.clk_en_in(1'b1), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
		.paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out), .status_initialization_in(halt),
		.status_observation_in(obs), .status_correction_in(corr),
		.status_classification_in(halt), .status_injection_in(halt), .status_heartbeat_in(hb),
		.status_uncorrectable_in(2'h0), .crc_fail_slice_in(crc), .halted_message_in(hmsg),
		.state_change_in(schg), .status_report_in(rep), .idle_command_in(1'b0),
		.corrected_valid_in(fixv), .corrected_addr_in(fixa), .status_cmd_ready_in(rdy),
		.status_cmd_out(cmd_out), .crc_fail_out(crc_fail_out), .fault_out(fault_out),
		.irq_out(irq_out));

	shs_ctrl_model u_model (.clock_in(clock_in), .rstn_in(rstn_in), .mode_in(mode),
		.slice_in(slice), .status_cmd_in(cmd_out), .obs_out(obs), .corr_out(corr),
		.halt_out(halt), .hb_out(hb), .crc_out(crc), .halted_msg_out(hmsg),
		.state_chg_out(schg), .report_out(rep), .fix_valid_out(fixv), .fix_addr_out(fixa),
		.ready_out(rdy));

	// Free-running 8 ns clock.
	initial
	begin
		clock_in = 1'b0;
		forever #4 clock_in = ~clock_in;
	end

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e)
		begin
			err_count++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic report_and_stop();
		$display("checked %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// One APB transfer; the expectation is queued before the request goes out.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] e, input logic er);
		int n;
		exp_q.push_back('{!w, e, er});
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clock_in);
		penable_in <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clock_in);
			n++;
		end
		while (pready_out !== 1'b1 && n < 50);
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		if (n >= 50)
		begin
			err_count++;
			report_and_stop();
		end
		@(posedge clock_in);
	endtask

	// Completed transfers are matched against the oldest note.
	always @(posedge clock_in)
	begin
		shs_exp_t x;
		if (cmd_out === 1'b1)
			cmd_cnt++;
		if (psel_in === 1'b1 && penable_in === 1'b1 && pready_out === 1'b1)
		begin
			x = exp_q.pop_front();
			chk("pslverr", pslverr_out, x.e);
			if (x.rd)
				chk("prdata", prdata_out, x.d);
		end
	end

	initial
	begin
		{psel_in, penable_in, pwrite_in, slice, mode} = '0;
		{paddr_in, pwdata_in} = '0;
		{err_count, checked, cmd_cnt} = '0;
		rstn_in = 1'b0;
		void'($urandom(32'h819a));
		repeat (10) @(posedge clock_in);
		rstn_in <= 1'b1;
		@(posedge clock_in);
		// Reset values, then an unmapped word that must be refused.
		for (int i = 0; i < 7; i++)
			apb(1'b0, ra[i], 32'h0, rv[i], i == 6);
		apb(1'b1, `SHS_ADDR_CMD_PERIOD, 32'h1, 32'h0, 1'b0);
		$display("test registers done");
		// Each fault mode on a random slice; odd rows run with every source masked.
		for (int i = 0; i < 8; i++)
		begin
			mask = i[0] ? 32'h0 : 32'h7F;
			apb(1'b1, `SHS_ADDR_MASK, mask, 32'h0, 1'b0);
			slice <= 1'($urandom % 2);
			mode <= rm[i];
			repeat (rw[i]) @(posedge clock_in);
			chk("irq", irq_out, |(re[i] & mask));
			chk("fault", fault_out, rf[i]);
			mode <= 3'h0;
			repeat (5) @(posedge clock_in);
			apb(1'b0, `SHS_ADDR_EVENT, 32'h0, re[i], 1'b0);
			apb(1'b1, `SHS_ADDR_CTRL, 32'hF, 32'h0, 1'b0);
			chk("cleared", fault_out, 1'b0);
			$display("test mode %0d done", rm[i]);
		end
		chk("commands", cmd_cnt != 0, 1'b1);
		report_and_stop();
	end
endmodule
`default_nettype wire
